//--- core/clock_source_startup_select.sv
`timescale 1ns/1ps
`default_nettype none

`include "clock_startup_consts.svh"

module clock_source_startup_select #(
    parameter logic [16:0] SHORT_TIMEOUT = `SHORT_TIMEOUT_CYCLES,
    parameter logic [16:0] LONG_TIMEOUT  = `LONG_TIMEOUT_CYCLES
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [3:0]               clock_source_fuses,
    input  wire logic [1:0]               startup_time_fuses,
    input  wire logic                     divide_by_eight_fuse,
    input  wire logic [7:0]               factory_calibration,
    input  wire logic                     clock_input_pin,
    input  wire logic                     rc_osc_clk,
    input  wire logic                     wdt_osc_clk,
    input  wire logic                     sleep_req,
    input  wire logic                     wake_req,
    output logic                          sys_clk_en,
    output logic                          wdt_tick,
    output logic                          rc_osc_enable,
    output logic                          rc_osc_8m,
    output logic [`TRIM_VALUE_MSB:0]      trim_value,
    output logic                          reset_timeout,
    output logic                          running,
    output clock_startup_pkg::source_t    clock_source
);
    import clock_startup_pkg::*;

    // decode of the sampled source fuses
    function automatic source_t decode_source(input logic [3:0] f);
        source_t s;
        s = SRC_EXT;
        if (f == `FUSE_RC4_LO || f == `FUSE_RC4_HI || f == `FUSE_RC8_LO || f == `FUSE_RC8_HI) begin
            s = SRC_RC;
        end else if (f == `FUSE_WDT_LO || f == `FUSE_WDT_HI) begin
            s = SRC_WDT;
        end else if (f == `FUSE_EXT_LO || f == `FUSE_EXT_HI) begin
            s = SRC_EXT;
        end
        return s;
    endfunction

    // watchdog cycles of the real-time part of the reset delay
    function automatic logic [16:0] timeout_of(input logic [1:0] code);
        logic [16:0] t;
        t = 17'h00000;
        unique case (code)
            `DELAY_NONE:     t = 17'h00000;
            `DELAY_SHORT:    t = SHORT_TIMEOUT;
            `DELAY_LONG:     t = LONG_TIMEOUT;
            `DELAY_RESERVED: t = LONG_TIMEOUT;
        endcase
        return t;
    endfunction

    logic ext_rise;
    logic rc_rise;
    logic wdt_rise;

    edge_sync u_ext_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (clock_input_pin),
        .level    (),
        .rise     (ext_rise)
    );

    edge_sync u_rc_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (rc_osc_clk),
        .level    (),
        .rise     (rc_rise)
    );

    edge_sync u_wdt_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (wdt_osc_clk),
        .level    (),
        .rise     (wdt_rise)
    );

    state_t      state_q,   state_d;
    logic [3:0]  srcsel_q,  srcsel_d;
    logic [1:0]  dly_q,     dly_d;
    logic        div8_q,    div8_d;
    source_t     src_q,     src_d;
    logic [16:0] cnt_q,     cnt_d;
    logic [2:0]  div_q,     div_d;
    logic [7:0]  trim_q,    trim_d;
    logic        clk_en_q,  clk_en_d;
    logic        wdt_q,     wdt_d;
    logic        rc_en_q,   rc_en_d;
    logic        rc8_q,     rc8_d;
    logic        tmo_q,     tmo_d;
    logic        run_q,     run_d;
    logic [31:0] prdata_q,  prdata_d;
    logic        pready_q,  pready_d;
    logic        pslverr_q, pslverr_d;

    logic        src_tick;
    logic        div_ok;
    logic        access;
    logic        wr_trim;

    // selected source edge and start-up divider
    always_comb begin
        unique case (src_q)
            SRC_EXT: src_tick = ext_rise;
            SRC_RC:  src_tick = rc_rise;
            SRC_WDT: src_tick = wdt_rise;
            default: src_tick = 1'b0;
        endcase
        div_ok = !div8_q || (div_q == `DIV_LAST);
    end

    // start-up sequencer
    always_comb begin
        state_d  = state_q;
        srcsel_d = srcsel_q;
        dly_d    = dly_q;
        div8_d   = div8_q;
        src_d    = src_q;
        cnt_d    = cnt_q;
        div_d    = div_q;
        clk_en_d = 1'b0;
        unique case (state_q)
            ST_CAPTURE: begin
                srcsel_d = clock_source_fuses;
                dly_d   = startup_time_fuses;
                div8_d  = !divide_by_eight_fuse;
                src_d   = decode_source(clock_source_fuses);
                cnt_d   = 17'h00000;
                state_d = ST_TIMEOUT;
            end
            ST_TIMEOUT: begin
                if (cnt_q >= timeout_of(dly_q)) begin
                    cnt_d   = 17'h00000;
                    state_d = ST_SETTLE;
                end else if (wdt_rise) begin
                    cnt_d = cnt_q + 17'h00001;
                end
            end
            ST_SETTLE: begin
                if (cnt_q >= {12'h000, `RESET_CYCLES}) begin
                    cnt_d   = 17'h00000;
                    div_d   = 3'h0;
                    state_d = ST_RUN;
                end else if (src_tick) begin
                    cnt_d = cnt_q + 17'h00001;
                end
            end
            ST_RUN: begin
                if (sleep_req) begin
                    state_d = ST_DOWN;
                end else if (src_tick) begin
                    clk_en_d = div_ok;
                    if (div8_q) begin
                        div_d = div_q + 3'h1;
                    end
                end
            end
            ST_DOWN: begin
                cnt_d = 17'h00000;
                if (wake_req) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (cnt_q >= {12'h000, `WAKE_CYCLES}) begin
                    cnt_d   = 17'h00000;
                    state_d = ST_RUN;
                end else if (src_tick) begin
                    cnt_d = cnt_q + 17'h00001;
                end
            end
            default: begin
                state_d = ST_CAPTURE;
            end
        endcase
    end

    // apb slave, one wait state
    always_comb begin
        access    = psel && penable;
        wr_trim   = access && pready_q && pwrite && (paddr == `REG_TRIM_OFFSET);
        pready_d  = access && !pready_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (access && !pready_q) begin
            prdata_d = 32'h00000000;
            if (paddr == `REG_TRIM_OFFSET) begin
                prdata_d = {24'h000000, trim_q};
            end else if (paddr == `REG_STATUS_OFFSET) begin
                prdata_d = {24'h000000, run_q, tmo_q, src_q, 1'b0, state_q};
            end else if (paddr == `REG_FUSE_OFFSET) begin
                prdata_d = {24'h000000, 1'b0, div8_q, dly_q, srcsel_q};
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    // trim register and outputs
    always_comb begin
        trim_d = trim_q;
        if (state_q == ST_CAPTURE) begin
            trim_d = factory_calibration;
        end else if (wr_trim) begin
            trim_d = pwdata[7:0];
        end
        wdt_d   = wdt_rise;
        rc_en_d = (src_d == SRC_RC) && (state_d != ST_DOWN);
        rc8_d   = (srcsel_d == `FUSE_RC8_LO) || (srcsel_d == `FUSE_RC8_HI);
        tmo_d   = (state_d == ST_CAPTURE) || (state_d == ST_TIMEOUT) || (state_d == ST_SETTLE);
        run_d   = (state_d == ST_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= ST_CAPTURE;
            srcsel_q  <= 4'h0;
            dly_q     <= 2'h0;
            div8_q    <= 1'b0;
            src_q     <= SRC_EXT;
            cnt_q     <= 17'h00000;
            div_q     <= 3'h0;
            trim_q    <= `TRIM_RESET;
            clk_en_q  <= 1'b0;
            wdt_q     <= 1'b0;
            rc_en_q   <= 1'b0;
            rc8_q     <= 1'b0;
            tmo_q     <= 1'b1;
            run_q     <= 1'b0;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            srcsel_q  <= srcsel_d;
            dly_q     <= dly_d;
            div8_q    <= div8_d;
            src_q     <= src_d;
            cnt_q     <= cnt_d;
            div_q     <= div_d;
            trim_q    <= trim_d;
            clk_en_q  <= clk_en_d;
            wdt_q     <= wdt_d;
            rc_en_q   <= rc_en_d;
            rc8_q     <= rc8_d;
            tmo_q     <= tmo_d;
            run_q     <= run_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign sys_clk_en    = clk_en_q;
    assign wdt_tick      = wdt_q;
    assign rc_osc_enable = rc_en_q;
    assign rc_osc_8m     = rc8_q;
    assign trim_value    = trim_q[`TRIM_VALUE_MSB:0];
    assign reset_timeout = tmo_q;
    assign running       = run_q;
    assign clock_source  = src_q;

endmodule

`default_nettype wire

//--- core/clock_startup_consts.svh
`ifndef CLOCK_STARTUP_CONSTS_SVH
`define CLOCK_STARTUP_CONSTS_SVH

// register byte offsets
`define REG_TRIM_OFFSET      12'h000
`define REG_STATUS_OFFSET    12'h004
`define REG_FUSE_OFFSET      12'h008

// clock source fuse codes
`define FUSE_EXT_LO          4'h0
`define FUSE_EXT_HI          4'h1
`define FUSE_RC4_LO          4'h2
`define FUSE_RC4_HI          4'h3
`define FUSE_RC8_LO          4'h4
`define FUSE_RC8_HI          4'h5
`define FUSE_WDT_LO          4'h6
`define FUSE_WDT_HI          4'h7

// start-up fuse codes
`define DELAY_NONE           2'h0
`define DELAY_SHORT          2'h1
`define DELAY_LONG           2'h2
`define DELAY_RESERVED       2'h3

// start-up counts in source clock cycles
`define WAKE_CYCLES          5'd6
`define RESET_CYCLES         5'd14

// reset time-outs in watchdog oscillator cycles
`define SHORT_TIMEOUT_CYCLES 17'd4096
`define LONG_TIMEOUT_CYCLES  17'd65536

// start-up divider
`define DIV_RATIO            4'd8
`define DIV_LAST             3'h7

// trim field
`define TRIM_VALUE_MSB       6
`define TRIM_RESET           8'h00

`endif

//--- core/clock_startup_pkg.sv
package clock_startup_pkg;

    typedef enum logic [2:0] {
        ST_CAPTURE = 3'b000,
        ST_TIMEOUT = 3'b001,
        ST_SETTLE  = 3'b010,
        ST_RUN     = 3'b011,
        ST_DOWN    = 3'b100,
        ST_WAKE    = 3'b101
    } state_t;

    typedef enum logic [1:0] {
        SRC_EXT = 2'b00,
        SRC_RC  = 2'b01,
        SRC_WDT = 2'b10
    } source_t;

endpackage

//--- core/edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser with a one-cycle rising-edge pulse
module edge_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);

    logic meta_q;
    logic sync_q;
    logic last_q;
    logic rise_q;
    logic rise_d;

    always_comb begin
        rise_d = sync_q & ~last_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
            rise_q <= rise_d;
        end
    end

    assign level = sync_q;
    assign rise  = rise_q;

endmodule

`default_nettype wire

//--- test/ext_clock_source.sv
`timescale 1ns/1ps
`default_nettype none

// free-running external clock source on the clock input pin
module ext_clock_source #(
    parameter realtime HALF = 100.0
) (
    output logic clk
);
    // 5 mhz, inside the input range and slow enough for the 20 mhz edge sampler
    // constant period, no cycle-to-cycle jumps
    initial begin
        clk = 1'b0;
        forever #(HALF) clk = ~clk;
    end
endmodule

`default_nettype wire

//--- test/clock_startup_chk.sv
`timescale 1ns/1ps
`default_nettype none

`include "clock_startup_consts.svh"

module clock_startup_chk (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [11:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       sys_clk_en,
    input wire logic                       wdt_tick,
    input wire logic                       rc_osc_enable,
    input wire logic [`TRIM_VALUE_MSB:0]   trim_value,
    input wire logic                       reset_timeout,
    input wire logic                       running,
    input wire clock_startup_pkg::source_t clock_source
);
    import clock_startup_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = paddr == `REG_TRIM_OFFSET || paddr == `REG_STATUS_OFFSET || paddr == `REG_FUSE_OFFSET;

    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not given one cycle into access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_flag: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    a_err_data: assert property (pready && !mapped |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_trim_write: assert property (pready && pwrite && paddr == `REG_TRIM_OFFSET |=> trim_value == $past(pwdata[6:0]))
        else $error("trim value not taken from write");
    a_clock_gated: assert property (reset_timeout |-> !sys_clk_en)
        else $error("system clock enabled during start-up");
    a_run_state: assert property (running |-> !reset_timeout)
        else $error("running while start-up delay active");
    a_source_hold: assert property (!reset_timeout && $past(!reset_timeout) |-> $stable(clock_source))
        else $error("clock source changed after start-up");
    a_rc_enable: assert property (running |-> rc_osc_enable == (clock_source == SRC_RC))
        else $error("rc enable does not follow source");
    a_tick_pulse: assert property (wdt_tick |=> !wdt_tick)
        else $error("watchdog tick longer than one cycle");
endmodule

bind clock_source_startup_select clock_startup_chk chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sys_clk_en, .wdt_tick, .rc_osc_enable, .trim_value, .reset_timeout,
    .running, .clock_source);

`default_nettype wire

//--- test/test_clock_source_startup_select.sv
`timescale 1ns/1ps
`default_nettype none

module test_clock_source_startup_select;
    import clock_startup_pkg::*;
    localparam int SHORT = 8;
    localparam int LONG  = 16;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  clock_source_fuses;
    logic [1:0]  startup_time_fuses;
    logic        divide_by_eight_fuse, clock_input_pin, rc_osc_clk, wdt_osc_clk, sleep_req, wake_req;
    logic [7:0]  factory_calibration;
    logic        sys_clk_en, wdt_tick, rc_osc_enable, rc_osc_8m, reset_timeout, running;
    logic [6:0]  trim_value;
    source_t     clock_source;
    int          failures = 0;
    int          tests_run = 0;

    clock_source_startup_select #(.SHORT_TIMEOUT(17'(SHORT)), .LONG_TIMEOUT(17'(LONG))) clock_source_startup_select_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_source_fuses(clock_source_fuses), .startup_time_fuses(startup_time_fuses),
        .divide_by_eight_fuse(divide_by_eight_fuse), .factory_calibration(factory_calibration),
        .clock_input_pin(clock_input_pin), .rc_osc_clk(rc_osc_clk), .wdt_osc_clk(wdt_osc_clk),
        .sleep_req(sleep_req), .wake_req(wake_req), .sys_clk_en(sys_clk_en), .wdt_tick(wdt_tick),
        .rc_osc_enable(rc_osc_enable), .rc_osc_8m(rc_osc_8m), .trim_value(trim_value),
        .reset_timeout(reset_timeout), .running(running), .clock_source(clock_source));
    ext_clock_source #(.HALF(100.0)) ext_clock_source_inst (.clk(clock_input_pin));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        rc_osc_clk = 1'b0;
        forever #62.5 rc_osc_clk = ~rc_osc_clk;
    end
    initial begin
        wdt_osc_clk = 1'b0;
        forever #1000 wdt_osc_clk = ~wdt_osc_clk;
    end

    function automatic source_t exp_src(input logic [3:0] c);
        if (c[3:1] == 3'b001 || c[3:1] == 3'b010) return SRC_RC;
        if (c[3:1] == 3'b011) return SRC_WDT;
        return SRC_EXT;
    endfunction
    function automatic int period(input source_t s);
        return (s == SRC_RC) ? 125 : (s == SRC_WDT) ? 2000 : 200;
    endfunction

    task automatic summarize;
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk("pready", 1, pready);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_cfg(input logic [3:0] c, input logic [1:0] s, input logic dv);
        source_t     e;
        int          p, t, n, k;
        logic [7:0]  cal, w;
        logic [31:0] r;
        logic        er;
        cal = 8'($urandom);
        e = exp_src(c);
        p = period(e);
        t = (s == 2'b00) ? 0 : (s == 2'b01) ? SHORT : LONG;
        @(posedge pclk);
        presetn <= 1'b0;
        clock_source_fuses <= c;
        startup_time_fuses <= s;
        divide_by_eight_fuse <= dv;
        factory_calibration <= cal;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(negedge pclk);
        chk("source", e, clock_source);
        chk("rc enable", e == SRC_RC, rc_osc_enable);
        if (e == SRC_RC) chk("rc 8m", c[3:1] == 3'b010, rc_osc_8m);
        chk("factory trim", cal[6:0], trim_value);
        n = 0;
        k = 0;
        while (running !== 1'b1 && k < 5000) begin
            @(negedge pclk);
            n += int'(wdt_tick);
            k++;
        end
        chk("timeout ticks", 1, n >= t && n <= t + ((e == SRC_WDT) ? 16 : 2));
        n = 0;
        repeat (800) begin
            @(negedge pclk);
            n += int'(sys_clk_en);
        end
        k = 800 * 50 / p / (dv ? 1 : 8);
        chk("clock rate", 1, n >= k - 3 && n <= k + 3);
        @(posedge pclk);
        sleep_req <= 1'b1;
        @(posedge pclk);
        sleep_req <= 1'b0;
        repeat (3) @(negedge pclk);
        chk("powered down", 0, running);
        chk("rc off", 0, rc_osc_enable);
        @(posedge pclk);
        wake_req <= 1'b1;
        @(posedge pclk);
        wake_req <= 1'b0;
        k = 1;
        while (running !== 1'b1 && k < 1000) begin
            @(negedge pclk);
            k++;
        end
        chk("wake time", 1, k * 50 >= 5 * p && k * 50 <= 7 * p + 400);
        w = {1'b0, cal[6:0]} ^ 8'($urandom & 32'h1f);
        apb(1'b1, 12'h000, {24'h0, w}, r, er);
        apb(1'b0, 12'h000, 32'h0, r, er);
        chk("trim read", {24'h0, w}, r);
        chk("trim port", w[6:0], trim_value);
        apb(1'b1, 12'h00c, 32'h55, r, er);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, r);
        apb(1'b0, 12'h000, 32'h0, r, er);
        chk("trim kept", {24'h0, w}, r);
        apb(1'b0, 12'h008, 32'h0, r, er);
        chk("fuse snapshot", {25'h0, !dv, s, c}, r);
        apb(1'b0, 12'h004, 32'h0, r, er);
        chk("status", {24'h0, 2'b10, e, 4'h3}, r);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        clock_source_fuses = 4'h2;
        startup_time_fuses = 2'h2;
        divide_by_eight_fuse = 1'b0;
        factory_calibration = 8'h40;
        sleep_req = 1'b0;
        wake_req = 1'b0;
        void'($urandom(32'h21a53a74));
        for (int i = 0; i < 12; i++) begin
            if (i < 8)
                run_cfg(4'(i), 2'(i), 1'(i >> 2));
            else
                run_cfg(4'($urandom), 2'($urandom), 1'($urandom));
        end
        summarize();
    end
    initial begin
        repeat (80000) @(posedge pclk);
        failures++;
        summarize();
    end
endmodule

`default_nettype wire
